// file: logic/acr_pkg.sv
// Constants for the converter configuration and status register bank.
// Assumes an AXI4-Lite master with 32-bit data and byte addresses.
// Summary of operation
// - Configuration-ready reads 0 during fuse load, then 1 once fuses apply.
// - Writing 1 to soft reset restores all register defaults except configuration-ready, then self-clears.
// - Global power-down bit 4 set powers the whole device down.
// - A general-purpose input pin can also command global power-down.
// - Writing 1 to detect-clear bit 6 resets the sync-detected flag.
// - Input termination select: 0 gives 100 ohm, 1 gives 200 ohm.
// - Writing 2 into the over-range clear field clears the sticky indication.
// - Sticky 0 follows the stretched pulse; sticky 1 holds until cleared.
// - Each over-range pulse is held for length field more cycles; a one-cycle pulse lasts length field plus one.
// - LVDS termination bit 7 set gives 100 ohm, clear gives 50 ohm.
// - Half-swing bit 5 set halves the LVDS output swing.
// - Output rate bit 2, default 1: 0 is DDR, 1 is SDR.

package acr_pkg;

   // ------------------------------------------------------------------
   // Bus geometry and responses
   // ------------------------------------------------------------------
   localparam int         ADDR_W      = 12;
   localparam int         IDX_W       = 10;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------------
   // Register indices; byte address is four times the index
   // ------------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_CFG_READY  = 10'h025;
   localparam logic [IDX_W-1:0] IDX_SOFT_RESET = 10'h100;
   localparam logic [IDX_W-1:0] IDX_POWERDOWN  = 10'h101;
   localparam logic [IDX_W-1:0] IDX_DET_CLEAR  = 10'h102;
   localparam logic [IDX_W-1:0] IDX_INPUT_TERM = 10'h104;
   localparam logic [IDX_W-1:0] IDX_OVR_MODE   = 10'h10A;
   localparam logic [IDX_W-1:0] IDX_OVR_LENGTH = 10'h10B;
   localparam logic [IDX_W-1:0] IDX_LINK_CFG   = 10'h110;
   localparam logic [IDX_W-1:0] IDX_STATUS     = 10'h140;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h180;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 10'h181;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int         BIT_CFG_READY  = 4;
   localparam int         BIT_SOFT_RESET = 0;
   localparam int         BIT_POWERDOWN  = 4;
   localparam int         BIT_DET_CLEAR  = 6;
   localparam int         BIT_INPUT_TERM = 0;
   localparam int         BIT_OVR_STICKY = 0;
   localparam int         OVR_CLR_LO     = 1;
   localparam logic [1:0] OVR_CLEAR_CODE = 2'h2;
   localparam int         BIT_LVDS_TERM  = 7;
   localparam int         BIT_HALF_SWING = 5;
   localparam int         BIT_RATE_SEL   = 2;
   localparam int         BIT_DET_FLAG   = 6;
   localparam int         BIT_OVR_STATUS = 0;
   localparam int         IRQ_W          = 3;
   localparam int         IRQ_CFG_READY  = 0;
   localparam int         IRQ_SYNC_DET   = 1;
   localparam int         IRQ_OVERRANGE  = 2;

   // ------------------------------------------------------------------
   // Values after reset
   // ------------------------------------------------------------------
   localparam logic             RST_BIT      = 1'b0;
   localparam logic             RST_RATE_SEL = 1'b1;
   localparam logic [1:0]       RST_OVR_CLR  = 2'h0;
   localparam logic [7:0]       RST_OVR_LEN  = 8'h00;
   localparam logic [IRQ_W-1:0] RST_IRQ      = 3'h0;

endpackage : acr_pkg

// file: logic/acr_regs.sv
// Configuration and status register bank with AXI4-Lite slave and interrupt.
// Assumes fuse-load and over-range inputs come from logic on mclk_i.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns

module acr_regs
(
   input  wire logic                       mclk_i,
   input  wire logic                       rst_i,
   input  wire logic                       ce_i,
   input  wire logic [acr_pkg::ADDR_W-1:0] s_axi_awaddr_i,
   input  wire logic                       s_axi_awvalid_i,
   output wire logic                       s_axi_awready_o,
   input  wire logic [31:0]                s_axi_wdata_i,
   input  wire logic [3:0]                 s_axi_wstrb_i,
   input  wire logic                       s_axi_wvalid_i,
   output wire logic                       s_axi_wready_o,
   output wire logic [1:0]                 s_axi_bresp_o,
   output wire logic                       s_axi_bvalid_o,
   input  wire logic                       s_axi_bready_i,
   input  wire logic [acr_pkg::ADDR_W-1:0] s_axi_araddr_i,
   input  wire logic                       s_axi_arvalid_i,
   output wire logic                       s_axi_arready_o,
   output wire logic [31:0]                s_axi_rdata_o,
   output wire logic [1:0]                 s_axi_rresp_o,
   output wire logic                       s_axi_rvalid_o,
   input  wire logic                       s_axi_rready_i,
   input  wire logic                       fuse_loaded_i,
   input  wire logic                       gpio_powerdown_i,
   input  wire logic                       sync_ref_i,
   input  wire logic                       overrange_i,
   output wire logic                       config_ready_o,
   output wire logic                       global_powerdown_o,
   output wire logic                       input_term_200_o,
   output wire logic                       lvds_term_100_o,
   output wire logic                       lvds_half_swing_o,
   output wire logic                       output_rate_sdr_o,
   output wire logic                       overrange_o,
   output wire logic                       irq_o
);
   import acr_pkg::*;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   logic              aw_held, w_held, bvalid, rvalid;
   logic [IDX_W-1:0]  aw_idx;
   logic [7:0]        w_byte;
   logic              w_lane0;
   logic [1:0]        bresp, rresp;
   logic [31:0]       rdata;
   logic              cfg_rdy, soft_rst, pdn, det_clr, term;
   logic              sticky, lvds_term, half_swing, rate_sdr;
   logic [1:0]        ovr_clr;
   logic [7:0]        ovr_len, ovr_cnt;
   logic              ovr_str, ovr_latch, sync_flag;
   logic              gpio_s1, gpio_s2, sync_s1, sync_s2, sync_s3;
   logic [IRQ_W-1:0]  irq_st, irq_mask;

   function automatic logic [7:0] place(input logic v, input int pos);
      logic [7:0] r;
      r      = 8'h00;
      r[pos] = v;
      return r;
   endfunction : place

   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------
   wire              wr_go   = aw_held & w_held & ~bvalid;
   wire              rd_go   = s_axi_arvalid_i & ~rvalid;
   wire [IDX_W-1:0]  ar_idx  = s_axi_araddr_i[ADDR_W-1:2];
   wire              wr_en   = wr_go & w_lane0;

   wire wr_known = (aw_idx == IDX_CFG_READY) || (aw_idx == IDX_SOFT_RESET)
                || (aw_idx == IDX_POWERDOWN) || (aw_idx == IDX_DET_CLEAR)
                || (aw_idx == IDX_INPUT_TERM) || (aw_idx == IDX_OVR_MODE)
                || (aw_idx == IDX_OVR_LENGTH) || (aw_idx == IDX_LINK_CFG)
                || (aw_idx == IDX_STATUS) || (aw_idx == IDX_IRQ_STATUS)
                || (aw_idx == IDX_IRQ_MASK);

   wire we_rst  = wr_en & (aw_idx == IDX_SOFT_RESET);
   wire we_pdn  = wr_en & (aw_idx == IDX_POWERDOWN);
   wire we_det  = wr_en & (aw_idx == IDX_DET_CLEAR);
   wire we_term = wr_en & (aw_idx == IDX_INPUT_TERM);
   wire we_mode = wr_en & (aw_idx == IDX_OVR_MODE);
   wire we_len  = wr_en & (aw_idx == IDX_OVR_LENGTH);
   wire we_link = wr_en & (aw_idx == IDX_LINK_CFG);
   wire we_ist  = wr_en & (aw_idx == IDX_IRQ_STATUS);
   wire we_imsk = wr_en & (aw_idx == IDX_IRQ_MASK);

   // Reserved bits are never stored, so they read back as zero.
   wire [7:0] rd_link = place(lvds_term, BIT_LVDS_TERM)
                      | place(half_swing, BIT_HALF_SWING)
                      | place(rate_sdr, BIT_RATE_SEL);
   wire [7:0] rd_mode = place(sticky, BIT_OVR_STICKY)
                      | {5'h00, ovr_clr, 1'b0};
   wire [7:0] rd_stat = place(sync_flag, BIT_DET_FLAG)
                      | place(overrange_o, BIT_OVR_STATUS);

   wire       rd_known;
   wire [7:0] rd_byte;
   assign {rd_known, rd_byte} =
        (ar_idx == IDX_CFG_READY)  ? {1'b1, place(cfg_rdy, BIT_CFG_READY)}
      : (ar_idx == IDX_SOFT_RESET) ? {1'b1, place(soft_rst, BIT_SOFT_RESET)}
      : (ar_idx == IDX_POWERDOWN)  ? {1'b1, place(pdn, BIT_POWERDOWN)}
      : (ar_idx == IDX_DET_CLEAR)  ? {1'b1, place(det_clr, BIT_DET_CLEAR)}
      : (ar_idx == IDX_INPUT_TERM) ? {1'b1, place(term, BIT_INPUT_TERM)}
      : (ar_idx == IDX_OVR_MODE)   ? {1'b1, rd_mode}
      : (ar_idx == IDX_OVR_LENGTH) ? {1'b1, ovr_len}
      : (ar_idx == IDX_LINK_CFG)   ? {1'b1, rd_link}
      : (ar_idx == IDX_STATUS)     ? {1'b1, rd_stat}
      : (ar_idx == IDX_IRQ_STATUS) ? {1'b1, 5'h00, irq_st}
      : (ar_idx == IDX_IRQ_MASK)   ? {1'b1, 5'h00, irq_mask}
      : {1'b0, 8'h00};

   // ------------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         bvalid  <= 1'b0;
         rvalid  <= 1'b0;
         aw_idx  <= '0;
         w_byte  <= 8'h00;
         w_lane0 <= 1'b0;
         bresp   <= RESP_OKAY;
         rresp   <= RESP_OKAY;
         rdata   <= 32'h0000_0000;
      end
      else if (ce_i)
      begin
         if (s_axi_awvalid_i && s_axi_awready_o)
         begin
            aw_held <= 1'b1;
            aw_idx  <= s_axi_awaddr_i[ADDR_W-1:2];
         end
         if (s_axi_wvalid_i && s_axi_wready_o)
         begin
            w_held  <= 1'b1;
            w_byte  <= s_axi_wdata_i[7:0];
            w_lane0 <= s_axi_wstrb_i[0];
         end
         if (wr_go)
         begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bvalid && s_axi_bready_i)
            bvalid <= 1'b0;
         if (rd_go)
         begin
            rvalid <= 1'b1;
            rdata  <= {24'h000000, rd_byte};
            rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
         end
         else if (rvalid && s_axi_rready_i)
            rvalid <= 1'b0;
      end
   end

   assign s_axi_awready_o = ~aw_held & ~bvalid;
   assign s_axi_wready_o  = ~w_held & ~bvalid;
   assign s_axi_bvalid_o  = bvalid;
   assign s_axi_bresp_o   = bresp;
   assign s_axi_arready_o = ~rvalid;
   assign s_axi_rvalid_o  = rvalid;
   assign s_axi_rdata_o   = rdata;
   assign s_axi_rresp_o   = rresp;

   // ------------------------------------------------------------------
   // Pin synchronisers and event detection
   // ------------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         {gpio_s1, gpio_s2} <= 2'h0;
         {sync_s1, sync_s2, sync_s3} <= 3'h0;
      end
      else if (ce_i)
      begin
         gpio_s1 <= gpio_powerdown_i;
         gpio_s2 <= gpio_s1;
         sync_s1 <= sync_ref_i;
         sync_s2 <= sync_s1;
         sync_s3 <= sync_s2;
      end
   end

   wire sync_rise = sync_s2 & ~sync_s3;
   wire cfg_set   = fuse_loaded_i & ~cfg_rdy;
   // Soft reset waits for the clock enable so that a frozen block stays put.
   wire reg_clr   = rst_i | (soft_rst & ce_i);

   // ------------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------------
   // Fuse state survives a soft reset; only a hardware reset reloads it.
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         cfg_rdy <= RST_BIT;
      else if (ce_i && cfg_set)
         cfg_rdy <= 1'b1;
   end

   always_ff @(posedge mclk_i)
   begin
      if (reg_clr)
      begin
         soft_rst   <= RST_BIT;
         pdn        <= RST_BIT;
         det_clr    <= RST_BIT;
         term       <= RST_BIT;
         sticky     <= RST_BIT;
         ovr_clr    <= RST_OVR_CLR;
         ovr_len    <= RST_OVR_LEN;
         lvds_term  <= RST_BIT;
         half_swing <= RST_BIT;
         rate_sdr   <= RST_RATE_SEL;
         irq_mask   <= RST_IRQ;
      end
      else if (ce_i)
      begin
         if (we_rst)
            soft_rst <= w_byte[BIT_SOFT_RESET];
         if (we_pdn)
            pdn <= w_byte[BIT_POWERDOWN];
         if (we_det)
            det_clr <= w_byte[BIT_DET_CLEAR];
         if (we_term)
            term <= w_byte[BIT_INPUT_TERM];
         if (we_mode)
         begin
            sticky  <= w_byte[BIT_OVR_STICKY];
            ovr_clr <= w_byte[OVR_CLR_LO+:2];
         end
         if (we_len)
            ovr_len <= w_byte;
         if (we_link)
         begin
            lvds_term  <= w_byte[BIT_LVDS_TERM];
            half_swing <= w_byte[BIT_HALF_SWING];
            rate_sdr   <= w_byte[BIT_RATE_SEL];
         end
         if (we_imsk)
            irq_mask <= w_byte[IRQ_W-1:0];
      end
   end

   // ------------------------------------------------------------------
   // Sync detect flag and over-range stretcher
   // ------------------------------------------------------------------
   // A new event in the same cycle as a clear keeps its flag set.
   always_ff @(posedge mclk_i)
   begin
      if (reg_clr)
      begin
         sync_flag <= 1'b0;
         ovr_str   <= 1'b0;
         ovr_cnt   <= 8'h00;
         ovr_latch <= 1'b0;
      end
      else if (ce_i)
      begin
         if (sync_rise)
            sync_flag <= 1'b1;
         else if (det_clr)
            sync_flag <= 1'b0;
         if (overrange_i)
         begin
            ovr_str <= 1'b1;
            ovr_cnt <= ovr_len;
         end
         else if (ovr_cnt != 8'h00)
            ovr_cnt <= ovr_cnt - 8'h01;
         else
            ovr_str <= 1'b0;
         if (overrange_i)
            ovr_latch <= 1'b1;
         else if (ovr_clr == OVR_CLEAR_CODE)
            ovr_latch <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Interrupt status, write one to clear, set wins
   // ------------------------------------------------------------------
   wire [IRQ_W-1:0] irq_ev  = {overrange_i, sync_rise, cfg_set};
   wire [IRQ_W-1:0] irq_w1c = we_ist ? w_byte[IRQ_W-1:0] : RST_IRQ;

   always_ff @(posedge mclk_i)
   begin
      if (reg_clr)
         irq_st <= RST_IRQ;
      else if (ce_i)
         irq_st <= (irq_st & ~irq_w1c) | irq_ev;
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // Pin and register both command power-down; either one is enough.
   assign global_powerdown_o = pdn | gpio_s2;
   assign config_ready_o     = cfg_rdy;
   assign input_term_200_o   = term;
   assign lvds_term_100_o    = lvds_term;
   assign lvds_half_swing_o  = half_swing;
   // SDR is only meaningful when a single channel is sent out.
   assign output_rate_sdr_o  = rate_sdr;
   assign overrange_o        = sticky ? ovr_latch : ovr_str;
   assign irq_o              = |(irq_st & irq_mask);

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i || !ce_i);

   sequence s_hit;
      overrange_i && ovr_len == 8'h03;
   endsequence

   sequence s_quiet;
      (!overrange_i && ovr_len == 8'h03 && !soft_rst)[*4];
   endsequence

   a_cfg_ready_set: assert property
      (($rose(cfg_rdy) |-> $past(fuse_loaded_i))
       and (!fuse_loaded_i && !cfg_rdy |=> !cfg_rdy))
      else $error("Configuration ready changed without fuse load.");

   a_soft_reset_defaults: assert property
      (soft_rst |=> !soft_rst && !pdn && rate_sdr && ovr_len == 8'h00
       && irq_st == 3'h0 && !sticky)
      else $error("Soft reset did not restore defaults.");

   a_powerdown_sources: assert property
      (we_pdn && w_byte[BIT_POWERDOWN] && !soft_rst |=> global_powerdown_o)
      else $error("Power-down output mismatch.");

   a_gpio_powerdown: assert property
      (gpio_s1 && !soft_rst |=> global_powerdown_o)
      else $error("Pin power-down not honoured.");

   a_sync_clear: assert property
      (det_clr && !sync_rise && !soft_rst |=> !sync_flag)
      else $error("Sync detect flag not cleared.");

   a_sync_set: assert property
      (sync_rise && !soft_rst |=> sync_flag)
      else $error("Sync detect event lost.");

   a_term_select: assert property
      (we_term && !soft_rst
       |=> input_term_200_o == $past(w_byte[BIT_INPUT_TERM]))
      else $error("Input termination select mismatch.");

   a_ovr_clear: assert property
      (ovr_clr == OVR_CLEAR_CODE && !overrange_i && sticky && !we_mode
       |=> !overrange_o)
      else $error("Sticky over-range not cleared.");

   a_ovr_sticky_hold: assert property
      (sticky && ovr_latch && ovr_clr != OVR_CLEAR_CODE && !we_mode
       && !soft_rst |=> overrange_o)
      else $error("Sticky over-range dropped.");

   a_ovr_stretch_len: assert property
      (s_hit ##1 s_quiet |-> (ovr_str && $past(ovr_str, 3)) ##1 !ovr_str)
      else $error("Over-range stretch length wrong.");

   a_link_fields: assert property
      (we_link && !soft_rst |=> lvds_term_100_o == $past(w_byte[7])
       && lvds_half_swing_o == $past(w_byte[5])
       && output_rate_sdr_o == $past(w_byte[2]))
      else $error("Output link fields not applied.");

   a_irq_level: assert property
      ((irq_ev & irq_mask) != RST_IRQ && !soft_rst && !we_imsk |=> irq_o)
      else $error("Interrupt output mismatch.");

endmodule : acr_regs

// file: dv/tb_top.sv
// Self-checking bench for the converter configuration and status registers.
// Assumes acr_pkg and acr_regs are compiled first; the bench drives all pins.
`timescale 1ns/1ns

module tb_top;
   import acr_pkg::*;

   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   logic              mclk     = 1'b0;
   logic              rst      = 1'b1;
   logic              ce       = 1'b1;
   logic [ADDR_W-1:0] awaddr   = '0;
   logic              awvalid  = 1'b0;
   logic [31:0]       wdata    = '0;
   logic              wvalid   = 1'b0;
   logic              bready   = 1'b0;
   logic [ADDR_W-1:0] araddr   = '0;
   logic              arvalid  = 1'b0;
   logic              rready   = 1'b0;
   logic              fuse     = 1'b0;
   logic              gpio_pd  = 1'b0;
   logic              sync_ref = 1'b0;
   logic              ovr      = 1'b0;
   logic              awready, wready, bvalid, arready, rvalid;
   logic [1:0]        bresp, rresp, rsp;
   logic [31:0]       rdata, rd;
   logic              cfg_rdy, pd, term200, lterm, half, sdr, ovr_out, irq;
   logic [7:0]        lens [3] = '{8'h00, 8'h03, 8'hFF};
   int                err_total   = 0;
   int                checks_done = 0;
   int                cyc         = 0;
   int                cnt;

   acr_regs dut
   (
      .mclk_i(mclk), .rst_i(rst), .ce_i(ce),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .fuse_loaded_i(fuse),
      .gpio_powerdown_i(gpio_pd), .sync_ref_i(sync_ref),
      .overrange_i(ovr), .config_ready_o(cfg_rdy),
      .global_powerdown_o(pd), .input_term_200_o(term200),
      .lvds_term_100_o(lterm), .lvds_half_swing_o(half),
      .output_rate_sdr_o(sdr), .overrange_o(ovr_out), .irq_o(irq)
   );

   always #2 mclk = ~mclk;

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // Ready is sampled at the falling edge; inputs only move on rising edges,
   // so that value is the one the slave sees at the next rising edge.
   task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      logic ta;
      logic tw;
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done  = 1'b0;
      @(posedge mclk);
      awaddr  <= a;
      wdata   <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(negedge mclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         @(posedge mclk);
         if (ta) awvalid <= 1'b0;
         if (ta) aw_done = 1'b1;
         if (tw) wvalid <= 1'b0;
         if (tw) w_done = 1'b1;
      end
      do
      begin
         @(negedge mclk);
         ta  = bvalid;
         rsp = bresp;
         @(posedge mclk);
      end while (!ta);
      bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [ADDR_W-1:0] a);
      logic t;
      @(posedge mclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(negedge mclk);
         t = arvalid && arready;
         @(posedge mclk);
      end while (!t);
      arvalid <= 1'b0;
      do
      begin
         @(negedge mclk);
         t   = rvalid;
         rd  = rdata;
         rsp = rresp;
         @(posedge mclk);
      end while (!t);
      rready <= 1'b0;
   endtask : axi_rd

   task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
      axi_wr({idx, 2'b00}, d);
      chk("bresp", {30'h0, rsp}, {30'h0, RESP_OKAY});
      @(negedge mclk);
   endtask : wr

   task automatic rd_chk(input string name, input logic [IDX_W-1:0] idx,
                         input logic [31:0] exp);
      axi_rd({idx, 2'b00});
      chk("rresp", {30'h0, rsp}, {30'h0, RESP_OKAY});
      chk(name, rd, exp);
   endtask : rd_chk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask : wait_cyc

   task automatic ovr_pulse;
      @(posedge mclk);
      ovr <= 1'b1;
      @(posedge mclk);
      ovr <= 1'b0;
   endtask : ovr_pulse

   task automatic end_sim;
      $display("TB: checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim

   // A full run takes about 1400 cycles; the ceiling leaves ample margin.
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_total++;
         end_sim();
      end
   end

   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   initial
   begin
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      wait_cyc(2);
      chk("config_ready_o", cfg_rdy, 1'b0);
      rd_chk("cfg_ready", IDX_CFG_READY, 32'h0);
      @(posedge mclk);
      fuse <= 1'b1;
      wait_cyc(3);
      chk("config_ready_o", cfg_rdy, 1'b1);
      rd_chk("cfg_ready", IDX_CFG_READY, 32'h10);
      rd_chk("link_cfg", IDX_LINK_CFG, 32'h04);
      chk("output_rate_sdr_o", sdr, 1'b1);
      rd_chk("ovr_mode", IDX_OVR_MODE, 32'h0);
      wr(IDX_POWERDOWN, 8'h10);
      rd_chk("powerdown", IDX_POWERDOWN, 32'h10);
      chk("global_powerdown_o", pd, 1'b1);
      wr(IDX_POWERDOWN, 8'h00);
      chk("global_powerdown_o", pd, 1'b0);
      @(posedge mclk);
      gpio_pd <= 1'b1;
      wait_cyc(4);
      chk("global_powerdown_o", pd, 1'b1);
      @(posedge mclk);
      gpio_pd <= 1'b0;
      wait_cyc(4);
      chk("global_powerdown_o", pd, 1'b0);
      wr(IDX_INPUT_TERM, 8'h01);
      chk("input_term_200_o", term200, 1'b1);
      wr(IDX_INPUT_TERM, 8'h00);
      chk("input_term_200_o", term200, 1'b0);
      wr(IDX_LINK_CFG, 8'hA0);
      chk("lvds_term_100_o", lterm, 1'b1);
      chk("lvds_half_swing_o", half, 1'b1);
      chk("output_rate_sdr_o", sdr, 1'b0);
      rd_chk("link_cfg", IDX_LINK_CFG, 32'hA0);
      wr(IDX_LINK_CFG, 8'h04);
      chk("lvds_term_100_o", lterm, 1'b0);
      chk("lvds_half_swing_o", half, 1'b0);
      chk("output_rate_sdr_o", sdr, 1'b1);
      // Stretch length at both ends of the field and in between.
      foreach (lens[i])
      begin
         wr(IDX_OVR_LENGTH, lens[i]);
         ovr_pulse();
         cnt = 0;
         repeat (300)
         begin
            @(negedge mclk);
            if (ovr_out === 1'b1) cnt++;
         end
         chk("stretch", cnt, 32'(lens[i]) + 1);
      end
      wr(IDX_OVR_MODE, 8'h03);
      ovr_pulse();
      wait_cyc(300);
      chk("overrange_o", ovr_out, 1'b1);
      rd_chk("status", IDX_STATUS, 32'h01);
      wr(IDX_OVR_MODE, 8'h05);
      chk("overrange_o", ovr_out, 1'b0);
      wr(IDX_OVR_MODE, 8'h00);
      @(posedge mclk);
      sync_ref <= 1'b1;
      wait_cyc(5);
      rd_chk("status", IDX_STATUS, 32'h40);
      wr(IDX_DET_CLEAR, 8'h40);
      rd_chk("status", IDX_STATUS, 32'h00);
      wr(IDX_DET_CLEAR, 8'h00);
      @(posedge mclk);
      sync_ref <= 1'b0;
      wait_cyc(4);
      @(posedge mclk);
      sync_ref <= 1'b1;
      wait_cyc(5);
      rd_chk("status", IDX_STATUS, 32'h40);
      rd_chk("irq_status", IDX_IRQ_STATUS, 32'h07);
      chk("irq_o", irq, 1'b0);
      wr(IDX_IRQ_MASK, 8'h02);
      chk("irq_o", irq, 1'b1);
      wr(IDX_IRQ_STATUS, 8'h02);
      chk("irq_o", irq, 1'b0);
      rd_chk("irq_status", IDX_IRQ_STATUS, 32'h05);
      wr(IDX_IRQ_MASK, 8'h04);
      chk("irq_o", irq, 1'b1);
      wr(IDX_IRQ_STATUS, 8'h04);
      chk("irq_o", irq, 1'b0);
      ovr_pulse();
      wait_cyc(1);
      chk("irq_o", irq, 1'b1);
      wr(IDX_IRQ_STATUS, 8'h04);
      // An event while the clock enable is low must leave no trace.
      @(posedge mclk);
      ce <= 1'b0;
      ovr_pulse();
      @(posedge mclk);
      ce <= 1'b1;
      wait_cyc(2);
      rd_chk("irq_status", IDX_IRQ_STATUS, 32'h01);
      axi_rd(12'h008);
      chk("unmapped rresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
      chk("unmapped rdata", rd, 32'h0);
      axi_wr(12'h00C, 8'h5A);
      chk("unmapped bresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
      wr(IDX_LINK_CFG, 8'hA0);
      wr(IDX_POWERDOWN, 8'h10);
      wr(IDX_SOFT_RESET, 8'h01);
      wait_cyc(3);
      rd_chk("link_cfg", IDX_LINK_CFG, 32'h04);
      rd_chk("powerdown", IDX_POWERDOWN, 32'h00);
      rd_chk("soft_reset", IDX_SOFT_RESET, 32'h00);
      chk("global_powerdown_o", pd, 1'b0);
      chk("config_ready_o", cfg_rdy, 1'b1);
      end_sim();
   end

endmodule : tb_top
